// File: hw/cmd_decoder.sv
/*
  Core memory cycle mode decoder: decodes the bus request, sequences the
  clear/read/write phases, drives byte enables, hold flag, slave sync,
  stack discharge and drive supply gating. AHB-Lite slave for control/status.
  Assumes request pins are asynchronous and held until slave_sync_ack
  is seen (interlocked); core sense data is stable while strobed.
*/
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
module cmd_decoder
  import cmd_pkg::*;
#(
  parameter int READ_CYC  = CMD_READ_CYC,
  parameter int WRITE_CYC = CMD_WRITE_CYC
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // request pins from the bus master
  input  wire logic        req_sync_in,
  input  wire logic        mode_bit_high,
  input  wire logic        mode_bit_low,
  input  wire logic        byte_select_bit,
  input  wire logic [15:0] master_wdata,
  input  wire logic        bus_init,
  // straps and supply
  input  wire logic        read_only_strap,
  input  wire logic        power_fail_n,
  // core array side
  input  wire logic [15:0] core_sense_data,
  output logic      [15:0] core_write_data,
  output logic      [1:0]  byte_load,
  output logic      [1:0]  byte_reset,
  output logic      [1:0]  byte_strobe,
  output logic             read_phase,
  output logic             drive_current_pulse,
  output logic             stack_discharge_en,
  output logic             drive_supply_en,
  // answer to the master
  output logic      [15:0] master_rdata,
  output logic             data_out_en,
  output logic             slave_sync_ack,
  output logic             restore_hold
);

  // synchronised pins
  logic [5:0]  ctl_s;
  logic [15:0] wdata_s;
  logic        req_s;
  logic        mhi_s;
  logic        mlo_s;
  logic        bsel_s;
  logic        strap_s;
  logic        pwr_ok_s;

  cmd_sync3 #(.WIDTH(6)) u_sync_ctl (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .pin_in   ({req_sync_in, mode_bit_high, mode_bit_low, byte_select_bit,
                read_only_strap, power_fail_n}),
    .sync_out (ctl_s)
  );

  cmd_sync3 #(.WIDTH(16)) u_sync_data (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .pin_in   (master_wdata),
    .sync_out (wdata_s)
  );

  assign req_s    = ctl_s[5];
  assign mhi_s    = ctl_s[4];
  assign mlo_s    = ctl_s[3];
  assign bsel_s   = ctl_s[2];
  assign strap_s  = ctl_s[1];
  assign pwr_ok_s = ctl_s[0];

  // decode of the request
  cmd_cycle_type req_cyc;
  logic [1:0]    mode_code;

  always_comb begin
    mode_code = {mhi_s, mlo_s};
    if (strap_s) begin
      mode_code = CMD_MODE_READ;
    end
    case (mode_code)
      CMD_MODE_READ: req_cyc = CMD_CYC_READ;
      CMD_MODE_HOLD: req_cyc = CMD_CYC_HOLD;
      CMD_MODE_WORD: req_cyc = CMD_CYC_WORD;
      CMD_MODE_BYTE: req_cyc = bsel_s ? CMD_CYC_HI : CMD_CYC_LO;
      default:       req_cyc = CMD_CYC_READ;
    endcase
  end

  // sequencer state
  cmd_state_type        state_r;
  cmd_state_type        state_nxt;
  cmd_cycle_type        cyc_r;
  cmd_cycle_type        cyc_nxt;
  logic [CMD_CNT_W-1:0] cnt_r;
  logic [CMD_CNT_W-1:0] cnt_nxt;
  logic                 hold_r;
  logic                 hold_nxt;
  logic [15:0]          mdr_r;
  logic [15:0]          mdr_nxt;
  logic [1:0]           ctrl_r;
  logic [1:0]           ctrl_nxt;
  logic                 soft_init;
  logic                 is_write;
  logic [1:0]           sel_bytes;
  logic [1:0]           rst_v;
  logic [1:0]           stb_v;
  logic [1:0]           ld_v;
  logic                 rd_v;
  logic                 pulse_v;

  localparam logic [CMD_CNT_W-1:0] READ_LAST  = CMD_CNT_W'(READ_CYC - 1);
  localparam logic [CMD_CNT_W-1:0] WRITE_LAST = CMD_CNT_W'(WRITE_CYC - 1);

  assign is_write = (cyc_r == CMD_CYC_WORD) || (cyc_r == CMD_CYC_HI) ||
                    (cyc_r == CMD_CYC_LO);

  // bytes the master supplies; the other byte keeps its read value
  always_comb begin
    case (cyc_r)
      CMD_CYC_WORD: sel_bytes = 2'h3;
      CMD_CYC_HI:   sel_bytes = 2'h2;
      CMD_CYC_LO:   sel_bytes = 2'h1;
      default:      sel_bytes = 2'h0;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    cyc_nxt   = cyc_r;
    cnt_nxt   = cnt_r;
    hold_nxt  = hold_r;
    rst_v     = 2'h0;
    stb_v     = 2'h0;
    ld_v      = 2'h0;
    rd_v      = 1'b0;
    pulse_v   = 1'b0;
    case (state_r)
      CMD_ST_IDLE: begin
        if (req_s && ctrl_r[CMD_CTRL_EN_BIT]) begin
          cyc_nxt = req_cyc;
          cnt_nxt = '0;
          if (hold_r && (req_cyc == CMD_CYC_WORD || req_cyc == CMD_CYC_HI ||
                         req_cyc == CMD_CYC_LO)) begin
            state_nxt = CMD_ST_WRITE;
          end else begin
            state_nxt = CMD_ST_CLEAR;
          end
        end
      end
      CMD_ST_CLEAR: begin
        rst_v     = ~sel_bytes;
        state_nxt = CMD_ST_READ;
      end
      CMD_ST_READ: begin
        rd_v    = 1'b1;
        pulse_v = 1'b1;
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == READ_LAST) begin
          stb_v   = ~sel_bytes;
          cnt_nxt = '0;
          if (cyc_r == CMD_CYC_HOLD) begin
            hold_nxt  = 1'b1;
            state_nxt = CMD_ST_ACK;
          end else begin
            state_nxt = CMD_ST_WRITE;
          end
        end
      end
      CMD_ST_WRITE: begin
        pulse_v = 1'b1;
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == '0) begin
          ld_v = sel_bytes;
        end
        if (cnt_r == WRITE_LAST) begin
          cnt_nxt   = '0;
          state_nxt = CMD_ST_ACK;
          if (is_write) begin
            hold_nxt = 1'b0;
          end
        end
      end
      CMD_ST_ACK: begin
        if (!req_s) begin
          state_nxt = CMD_ST_IDLE;
        end
      end
      default: state_nxt = CMD_ST_IDLE;
    endcase
    if (bus_init || soft_init) begin
      hold_nxt  = 1'b0;
      state_nxt = CMD_ST_IDLE;
      cnt_nxt   = '0;
    end
  end

  // data register: clear, sense, then master bytes, each later one overriding the earlier
  always_comb begin
    mdr_nxt = mdr_r;
    for (int b = 0; b < 2; b++) begin
      if (rst_v[b]) begin
        mdr_nxt[b*8 +: 8] = 8'h00;
      end
      if (stb_v[b]) begin
        mdr_nxt[b*8 +: 8] = core_sense_data[b*8 +: 8];
      end
      if (ld_v[b]) begin
        mdr_nxt[b*8 +: 8] = wdata_s[b*8 +: 8];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= CMD_ST_IDLE;
      cyc_r   <= CMD_CYC_READ;
      cnt_r   <= '0;
      hold_r  <= 1'b0;
      mdr_r   <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      cyc_r   <= cyc_nxt;
      cnt_r   <= cnt_nxt;
      hold_r  <= hold_nxt;
      mdr_r   <= mdr_nxt;
    end
  end

  // registered core-side outputs
  logic [1:0] byte_load_r;
  logic [1:0] byte_reset_r;
  logic [1:0] byte_strobe_r;
  logic       read_phase_r;
  logic       pulse_r;
  logic       dout_r;
  logic       ack_r;
  logic       dout_nxt;
  logic       ack_nxt;

  always_comb begin
    ack_nxt  = (state_nxt == CMD_ST_ACK);
    dout_nxt = ack_nxt && (cyc_nxt == CMD_CYC_READ || cyc_nxt == CMD_CYC_HOLD);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      byte_load_r   <= 2'h0;
      byte_reset_r  <= 2'h0;
      byte_strobe_r <= 2'h0;
      read_phase_r  <= 1'b0;
      pulse_r       <= 1'b0;
      dout_r        <= 1'b0;
      ack_r         <= 1'b0;
    end else begin
      byte_load_r   <= ld_v;
      byte_reset_r  <= rst_v;
      byte_strobe_r <= stb_v;
      read_phase_r  <= rd_v;
      pulse_r       <= pulse_v;
      dout_r        <= dout_nxt;
      ack_r         <= ack_nxt;
    end
  end

  assign byte_load           = byte_load_r;
  assign byte_reset          = byte_reset_r;
  assign byte_strobe         = byte_strobe_r;
  assign read_phase          = read_phase_r;
  assign drive_current_pulse = pulse_r;
  assign stack_discharge_en  = pulse_r && !read_phase_r;
  // supply cut acts through the synchroniser; loss of logic power is analog
  assign drive_supply_en     = pwr_ok_s;
  assign core_write_data     = mdr_r;
  assign master_rdata        = mdr_r;
  assign data_out_en         = dout_r;
  assign slave_sync_ack      = ack_r;
  assign restore_hold        = hold_r;

  // ahb-lite slave, zero wait states
  logic        aph_wr_r;
  logic        aph_wr_nxt;
  logic [7:0]  aph_ofs_r;
  logic [7:0]  aph_ofs_nxt;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;
  logic        take;
  logic [31:0] status_word;

  assign take = hsel && hready && htrans[1];

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[CMD_ST_STATE_LSB +: 3] = state_r;
    status_word[CMD_ST_CYC_LSB +: 3]   = cyc_r;
    status_word[CMD_ST_PWR_BIT]        = pwr_ok_s;
    status_word[CMD_ST_STRAP_BIT]      = strap_s;
    status_word[CMD_ST_HOLD_BIT]       = hold_r;
  end

  always_comb begin
    aph_wr_nxt  = take && hwrite;
    aph_ofs_nxt = take ? haddr[7:0] : aph_ofs_r;
    hrdata_nxt  = hrdata_r;
    if (take && !hwrite) begin
      case (haddr[7:0])
        CMD_CTRL_OFS:   hrdata_nxt = {30'h0000_0000, ctrl_r};
        CMD_STATUS_OFS: hrdata_nxt = status_word;
        CMD_DATA_OFS:   hrdata_nxt = {16'h0000, mdr_r};
        default:        hrdata_nxt = 32'h0000_0000;
      endcase
    end
    // init bit self-clears after one cycle
    ctrl_nxt = ctrl_r & ~(2'h1 << CMD_CTRL_INIT_BIT);
    if (aph_wr_r && aph_ofs_r == CMD_CTRL_OFS) begin
      ctrl_nxt = hwdata[1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aph_wr_r  <= 1'b0;
      aph_ofs_r <= 8'h00;
      hrdata_r  <= 32'h0000_0000;
      ctrl_r    <= CMD_CTRL_RESET;
    end else begin
      aph_wr_r  <= aph_wr_nxt;
      aph_ofs_r <= aph_ofs_nxt;
      hrdata_r  <= hrdata_nxt;
      ctrl_r    <= ctrl_nxt;
    end
  end

  assign soft_init = ctrl_r[CMD_CTRL_INIT_BIT];
  assign hrdata    = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule // cmd_decoder

// File: common/cmd_pkg.sv
/*
  Constants, types and register map of the core memory cycle mode decoder.
  Assumes a 125 MHz system clock and a 32-bit AHB-Lite register bus.
*/
// Contract
// - mode bits plus byte select pick cycle
// - code 00 reads, restores, ignores byte select
// - code 01 sets hold flag, skips restore
// - code 10 writes whole 16-bit word
// - code 11, select 1: high byte only
// - code 11, select 0: low byte only
// - read-only strap forces plain read always
// - derive capture enables, qualify reset/strobe/data-out
// - decoder drives hold flag set or clear
// - mode terms condition slave sync clocking
// - write after held read skips read phase
// - write drive pulse enables stack discharge
// - read phase keeps stack discharge off
// - power fail cuts drive current supply
// - low byte write restores other byte
// - bus initialize clears hold flag
package cmd_pkg;

  // register byte offsets
  localparam logic [7:0] CMD_CTRL_OFS   = 8'h00;
  localparam logic [7:0] CMD_STATUS_OFS = 8'h04;
  localparam logic [7:0] CMD_DATA_OFS   = 8'h08;

  // control fields
  localparam int         CMD_CTRL_EN_BIT   = 0;
  localparam int         CMD_CTRL_INIT_BIT = 1;
  localparam logic [1:0] CMD_CTRL_RESET    = 2'h1;

  // status fields
  localparam int CMD_ST_STATE_LSB = 0;
  localparam int CMD_ST_CYC_LSB   = 3;
  localparam int CMD_ST_PWR_BIT   = 6;
  localparam int CMD_ST_STRAP_BIT = 7;
  localparam int CMD_ST_HOLD_BIT  = 8;

  // mode-control codes
  localparam logic [1:0] CMD_MODE_READ = 2'h0;
  localparam logic [1:0] CMD_MODE_HOLD = 2'h1;
  localparam logic [1:0] CMD_MODE_WORD = 2'h2;
  localparam logic [1:0] CMD_MODE_BYTE = 2'h3;

  // timing
  localparam int CMD_CLK_MHZ     = 125;
  localparam int CMD_READ_NS     = 100;
  localparam int CMD_WRITE_NS    = 200;
  localparam int CMD_READ_CYC    = (CMD_READ_NS * CMD_CLK_MHZ + 999) / 1000;
  localparam int CMD_WRITE_CYC   = (CMD_WRITE_NS * CMD_CLK_MHZ + 999) / 1000;
  localparam int CMD_CNT_W       = 8;

  typedef enum logic [2:0] {
    CMD_ST_IDLE  = 3'h0,
    CMD_ST_CLEAR = 3'h1,
    CMD_ST_READ  = 3'h3,
    CMD_ST_WRITE = 3'h2,
    CMD_ST_ACK   = 3'h6
  } cmd_state_type;

  typedef enum logic [2:0] {
    CMD_CYC_READ = 3'h0,
    CMD_CYC_HOLD = 3'h1,
    CMD_CYC_WORD = 3'h2,
    CMD_CYC_HI   = 3'h3,
    CMD_CYC_LO   = 3'h4
  } cmd_cycle_type;

endpackage

// File: hw/cmd_sync3.sv
/*
  Three-stage input synchroniser for a group of pins.
  Assumes inputs asynchronous to sys_clk; output follows once stages two and three agree.
*/
`timescale 1ns/1ps
module cmd_sync3 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // pins in, clean value out
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] out_r;
  logic [WIDTH-1:0] out_nxt;

  always_comb begin
    out_nxt = out_r;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        out_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      out_r <= '0;
    end else begin
      s1_r  <= pin_in;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign sync_out = out_r;

endmodule // cmd_sync3

// File: tb/cmd_decoder_checker.sv
/*
  Port checker of the cycle mode decoder, bound into cmd_decoder.
  Assumes a single sys_clk domain and the synchronous active-low rst_n.
*/
`timescale 1ns/1ps
module cmd_decoder_checker (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_n,
  // request side
  input wire logic       req_sync_in,
  input wire logic       bus_init,
  input wire logic       power_fail_n,
  // core and answer side
  input wire logic [1:0] byte_load,
  input wire logic [1:0] byte_reset,
  input wire logic [1:0] byte_strobe,
  input wire logic       read_phase,
  input wire logic       drive_current_pulse,
  input wire logic       stack_discharge_en,
  input wire logic       drive_supply_en,
  input wire logic       data_out_en,
  input wire logic       slave_sync_ack,
  input wire logic       restore_hold
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // margins cover the three-stage pin synchronisers
  sequence s_req_gone;
    !req_sync_in [*6];
  endsequence
  sequence s_pwr_gone;
    !power_fail_n [*5];
  endsequence
  a_discharge_on: assert property (drive_current_pulse && !read_phase |-> stack_discharge_en)
    else $error("stack discharge off in write phase");
  a_discharge_off: assert property (read_phase |-> !stack_discharge_en)
    else $error("stack discharge on in read phase");
  a_supply_cut: assert property (s_pwr_gone |-> !drive_supply_en)
    else $error("drive supply on during power fail");
  a_reset_then_read: assert property (|byte_reset |-> ##[1:2] read_phase)
    else $error("byte reset without read phase");
  a_strobe_after_read: assert property (|byte_strobe |-> $past(read_phase) || $past(read_phase, 2))
    else $error("byte strobe outside read");
  a_load_in_write: assert property (|byte_load |=> !read_phase)
    else $error("byte load during read");
  a_load_discharge: assert property (|byte_load |-> stack_discharge_en)
    else $error("no stack discharge at byte load");
  a_hold_init_clear: assert property (bus_init |=> !restore_hold)
    else $error("hold flag kept over init");
  a_hold_no_write: assert property ($rose(restore_hold) |-> !stack_discharge_en [*8])
    else $error("restore write after held read");
  a_data_out_ack: assert property (data_out_en |-> slave_sync_ack)
    else $error("data out without slave sync");
  a_ack_release: assert property (s_req_gone |-> !slave_sync_ack)
    else $error("slave sync kept after request low");
endmodule // cmd_decoder_checker

bind cmd_decoder cmd_decoder_checker cmd_decoder_checker_inst (
  .sys_clk(sys_clk), .rst_n(rst_n), .req_sync_in(req_sync_in), .bus_init(bus_init),
  .power_fail_n(power_fail_n), .byte_load(byte_load), .byte_reset(byte_reset),
  .byte_strobe(byte_strobe), .read_phase(read_phase), .drive_current_pulse(drive_current_pulse),
  .stack_discharge_en(stack_discharge_en), .drive_supply_en(drive_supply_en),
  .data_out_en(data_out_en), .slave_sync_ack(slave_sync_ack), .restore_hold(restore_hold)
);

// File: tb/cmd_bus_master.sv
/*
  Behavioural bus master driving the request pins with an interlocked handshake.
  Assumes go is a one-cycle pulse from the bench and ack comes from the decoder.
*/
`timescale 1ns/1ps
module cmd_bus_master (
  // clock
  input wire logic        sys_clk,
  // bench command
  input wire logic        go,
  input wire logic [1:0]  mode,
  input wire logic        sel,
  input wire logic [15:0] wdata,
  // pins
  input wire logic        slave_sync_ack,
  output logic            req_sync_in,
  output logic            mode_bit_high,
  output logic            mode_bit_low,
  output logic            byte_select_bit,
  output logic [15:0]     master_wdata,
  // result
  output int              lat,
  output logic            done
);
  initial begin
    req_sync_in = 0;
    {mode_bit_high, mode_bit_low, byte_select_bit, done} = 4'h0;
    master_wdata = 16'h0;
    forever begin
      @(posedge sys_clk);
      if (go) begin
        {mode_bit_high, mode_bit_low} <= mode;
        byte_select_bit <= sel;
        master_wdata <= wdata;
        req_sync_in <= 1;
        done <= 0;
        lat = 0;
        do begin
          @(posedge sys_clk);
          lat++;
        end while (slave_sync_ack !== 1'b1);
        req_sync_in <= 0;
        // released lines must not keep looking valid
        master_wdata <= ~wdata;
        while (slave_sync_ack === 1'b1) @(posedge sys_clk);
        done <= 1;
      end
    end
  end
endmodule // cmd_bus_master

// File: tb/tb_top.sv
/*
  Self-checking bench of the cycle mode decoder: AHB-Lite master, pin master model.
  Assumes short phase parameters; the hold and short-write latency expectations derive from them.
*/
`timescale 1ns/1ps
module tb_top;
  import cmd_pkg::*;
  localparam int RC = 3;
  localparam int WC = 4;
  logic        sys_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, go = 0, sel = 0;
  logic        bus_init = 0, strap = 0, pwr_n = 1;
  logic        hreadyout, hresp, req, mbh, mbl, bsel, ack, rhold, done, supply;
  logic [1:0]  htrans = 0, mode = 0, ld_seen, byte_load;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [15:0] wdata = 0, sense = 0, mwdata, mrd, cwd;
  int          bad_count = 0, n_compared = 0, lat, lat_std;
  always #4 sys_clk = ~sys_clk;
  always_ff @(posedge sys_clk) ld_seen <= go ? 2'h0 : ld_seen | byte_load;
  cmd_decoder #(.READ_CYC(RC), .WRITE_CYC(WC)) cmd_decoder_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .req_sync_in(req), .mode_bit_high(mbh),
    .mode_bit_low(mbl), .byte_select_bit(bsel), .master_wdata(mwdata), .bus_init(bus_init),
    .read_only_strap(strap), .power_fail_n(pwr_n), .core_sense_data(sense),
    .core_write_data(cwd), .byte_load(byte_load), .byte_reset(), .byte_strobe(), .read_phase(),
    .drive_current_pulse(), .stack_discharge_en(), .drive_supply_en(supply),
    .master_rdata(mrd), .data_out_en(), .slave_sync_ack(ack), .restore_hold(rhold));
  cmd_bus_master cmd_bus_master_inst (.sys_clk(sys_clk), .go(go), .mode(mode), .sel(sel),
    .wdata(wdata), .slave_sync_ack(ack), .req_sync_in(req), .mode_bit_high(mbh),
    .mode_bit_low(mbl), .byte_select_bit(bsel), .master_wdata(mwdata), .lat(lat), .done(done));
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wait_for(input int lim);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (n > lim) begin
        bad_count++;
        end_sim;
      end
    end while ((lim < 100 ? hreadyout : done) !== 1'b1);
  endtask
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_for(50);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_for(50);
    rd = hrdata;
  endtask
  task pin(input logic [1:0] m, input logic s);
    mode <= m;
    sel <= s;
    wdata <= 16'($urandom);
    sense <= 16'($urandom);
    go <= 1;
    @(posedge sys_clk);
    go <= 0;
    wait_for(500);
  endtask
  function automatic logic [15:0] exp_data(logic [1:0] m, logic s, logic [15:0] w, c);
    case (m)
      CMD_MODE_WORD: return w;
      CMD_MODE_BYTE: return s ? {w[15:8], c[7:0]} : {c[15:8], w[7:0]};
      default: return c;
    endcase
  endfunction
  task run(input logic [1:0] m, input logic s);
    logic [1:0]  em;
    logic [15:0] ed;
    em = strap ? CMD_MODE_READ : m;
    pin(m, s);
    ed = exp_data(em, s, wdata, sense);
    chk("data", mrd, ed);
    chk("core data", cwd, ed);
    chk("load", ld_seen, em == 2'h2 ? 2'h3 : em == 2'h3 ? {s, !s} : 2'h0);
    ahb(0, CMD_STATUS_OFS, 0);
    chk("cycle", rd[5:3], em == 2'h3 && !s ? CMD_CYC_LO : {1'b0, em});
    ahb(0, CMD_DATA_OFS, 0);
    chk("data reg", rd, {16'h0000, ed});
    if (em == CMD_MODE_WORD) lat_std = lat;
    // a plain read runs the same clear, read and restore phases as a word write
    if (em == CMD_MODE_READ) chk("restore time", lat, lat_std);
    if (em == CMD_MODE_HOLD) begin
      chk("hold time", lat, lat_std - WC);
      chk("hold", rhold, 1);
      pin(CMD_MODE_WORD, s);
      chk("short", lat, lat_std - 1 - RC);
      chk("hold clear", rhold, 0);
      chk("hold data", mrd, wdata);
    end
  endtask
  initial begin
    void'($urandom(32'hFAD62665));
    repeat (2) @(posedge sys_clk);
    rst_n <= 1;
    repeat (5) @(posedge sys_clk);
    chk("hresp", {hreadyout, hresp}, 2'h2);
    ahb(0, CMD_CTRL_OFS, 0);
    chk("ctrl", rd, 32'h1);
    ahb(0, 32'h0C, 0);
    chk("unmapped", rd, 0);
    run(CMD_MODE_WORD, 0);
    for (int i = 0; i < 8; i++) run(i[2:1], i[0]);
    repeat (8) run(2'($urandom), 1'($urandom));
    pin(CMD_MODE_HOLD, 0);
    chk("hold", rhold, 1);
    bus_init <= 1;
    @(posedge sys_clk);
    bus_init <= 0;
    @(posedge sys_clk);
    chk("init", rhold, 0);
    pin(CMD_MODE_HOLD, 1);
    chk("hold", rhold, 1);
    ahb(1, CMD_CTRL_OFS, 32'h3);
    // init bit is written at the edge ending the data phase, the flag clears one edge later
    repeat (2) @(posedge sys_clk);
    chk("soft init", rhold, 0);
    ahb(0, CMD_CTRL_OFS, 0);
    chk("init self clear", rd, 32'h1);
    strap <= 1;
    repeat (5) @(posedge sys_clk);
    run(CMD_MODE_WORD, 1);
    run(CMD_MODE_BYTE, 0);
    strap <= 0;
    pwr_n <= 0;
    repeat (6) @(posedge sys_clk);
    chk("supply off", supply, 0);
    pwr_n <= 1;
    repeat (6) @(posedge sys_clk);
    chk("supply on", supply, 1);
    end_sim;
  end
endmodule // tb_top
